// ===== fast_slow_jog_signal_sequencer_tb.sv
`timescale 1ns/1ps
module fast_slow_jog_signal_sequencer_tb;
    localparam int CPM = 4;
    logic mclk, rst_n, reg_wr, reg_rd, key_a, key_b, home_sw, fast_jog, slow_jog, dir_fwd, irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed, e, m;
    logic signed [31:0] act_pos, bump;
    logic rd_seen, fast_seen;
    logic [31:0] exp_q[$], msk_q[$];
    int fail_count, check_count, n, tgt, rem;
    logic [7:0] sa [10] = '{fjs_pkg::ADR_FWD_SLOW, fjs_pkg::ADR_FWD_COAST, fjs_pkg::ADR_REV_SLOW,
        fjs_pkg::ADR_REV_COAST, fjs_pkg::ADR_REV_SLOW_TIME, fjs_pkg::ADR_REV_COAST_TIME,
        fjs_pkg::ADR_START_DELAY, fjs_pkg::ADR_TOL_BELOW, fjs_pkg::ADR_TOL_ABOVE, fjs_pkg::ADR_IRQ_MASK};
    logic [31:0] sv [10] = '{32'h32, 32'ha, 32'h1e, 32'h5, 32'h1, 32'h2, 32'h2, 32'h14, 32'h14, 32'h0};
    fjs_sequencer #(.CYCLES_PER_MS(CPM)) dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .act_pos(act_pos),
        .key_a(key_a), .key_b(key_b), .home_sw(home_sw), .fast_jog(fast_jog), .slow_jog(slow_jog),
        .dir_fwd(dir_fwd), .irq(irq));
    fjs_drive_model drive (.mclk(mclk), .rst_n(rst_n), .fast_jog(fast_jog), .slow_jog(slow_jog),
        .dir_fwd(dir_fwd), .bump(bump), .act_pos(act_pos));
    // ==========================================================
    // Clock, helpers and watchers
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // The expected word is queued now and compared by the watcher when the data stand.
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    // Waits under a bound for a pin (0 fast, 1 slow, 2 direction) to reach a level.
    task automatic wait_pin(input int which, input logic val, input int lim, output int cnt);
        logic s;
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
            s = (which == 0) ? fast_jog : ((which == 1) ? slow_jog : dir_fwd);
        end while (s !== val && cnt < lim);
        if (s !== val) begin
            fail_count++;
            $display("BAD t=%0t pin %0d got=%h exp=%h", $time, which, s, val);
            wrap_up();
        end
    endtask
    always @(posedge mclk) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(reg_rdata & m, e);
        end
        rd_seen <= reg_rd;
        if (fast_jog === 1'b1) fast_seen = 1'b1;
    end
    initial begin
        #300000;
        fail_count++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, reg_wr, reg_rd, key_a, key_b, home_sw, rd_seen, fast_seen} = 8'h0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        bump = 32'sd0;
        seed = 32'h63ea8a36;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rd(fjs_pkg::ADR_STATUS, 32'h0, 32'hffffffff);
        rd(fjs_pkg::ADR_CMD, 32'h0, 32'hffffffff);
        seed = lfsr(seed);
        wr(8'h44, seed);
        rd(8'h44, 32'h0, 32'hffffffff);
        wr(fjs_pkg::ADR_FWD_SLOW, 32'hffffffff);
        rd(fjs_pkg::ADR_FWD_SLOW, {5'h0, fjs_pkg::DIST_MAX}, 32'hffffffff);
        wr(fjs_pkg::ADR_REV_COAST_TIME, 32'hffffffff);
        rd(fjs_pkg::ADR_REV_COAST_TIME, {18'h0, fjs_pkg::REV_TIME_MAX_MS}, 32'hffffffff);
        wr(fjs_pkg::ADR_START_DELAY, 32'hffffffff);
        rd(fjs_pkg::ADR_START_DELAY, {18'h0, fjs_pkg::START_DELAY_MAX_MS}, 32'hffffffff);
        for (int i = 0; i < 10; i++) wr(sa[i], sv[i]);
        // Forward positioning with fast jog allowed.
        wr(fjs_pkg::ADR_CFG, 32'h1);
        seed = lfsr(seed);
        tgt = act_pos + 200 + int'(seed[5:0]);
        wr(fjs_pkg::ADR_TARGET, 32'(tgt));
        wr(fjs_pkg::ADR_CMD, 32'h1);
        wait_pin(1, 1'b1, 60, n);
        chk(32'(n >= 2 * CPM - 2 && n <= 2 * CPM + 4), 32'h1);
        chk(32'(dir_fwd), 32'h1);
        wait_pin(0, 1'b1, 3, n);
        wait_pin(0, 1'b0, 200, n);
        rem = tgt - act_pos;
        chk(32'(rem <= 50 && rem >= 38 && slow_jog === 1'b1), 32'h1);
        wait_pin(1, 1'b0, 200, n);
        rem = tgt - act_pos;
        chk(32'(rem <= 10 && rem >= 7), 32'h1);
        repeat (3) @(posedge mclk);
        rd(fjs_pkg::ADR_STATUS, 32'h80, 32'hbf);
        rd(fjs_pkg::ADR_IRQ_STAT, 32'h1, 32'h1);
        #1;
        chk(32'(irq), 32'h0);
        wr(fjs_pkg::ADR_IRQ_MASK, 32'h1);
        #1;
        chk(32'(irq), 32'h1);
        wr(fjs_pkg::ADR_IRQ_STAT, 32'h1);
        #1;
        chk(32'(irq), 32'h0);
        bump <= -32'sd100;
        repeat (4) @(posedge mclk);
        rd(fjs_pkg::ADR_STATUS, 32'h0, 32'h80);
        rd(fjs_pkg::ADR_IRQ_STAT, 32'h4, 32'h4);
        // Backward into negative positions, slow jog only.
        wr(fjs_pkg::ADR_CFG, 32'h0);
        fast_seen = 1'b0;
        tgt = act_pos - 300;
        wr(fjs_pkg::ADR_TARGET, 32'(tgt));
        wr(fjs_pkg::ADR_CMD, 32'h1);
        wait_pin(1, 1'b1, 60, n);
        chk(32'(dir_fwd), 32'h0);
        wait_pin(1, 1'b0, 400, n);
        rem = act_pos - tgt;
        chk(32'(rem <= 5 && rem >= 2), 32'h1);
        chk(32'(fast_seen), 32'h0);
        // Reversal while jogging fast by hand: pressing the opposite key reverses a manual move through the brake and settle states.
        wr(fjs_pkg::ADR_CFG, 32'h2);
        key_a <= 1'b1;
        wait_pin(0, 1'b1, 20, n);
        key_a <= 1'b0;
        key_b <= 1'b1;
        wait_pin(0, 1'b0, 5, n);
        wait_pin(1, 1'b0, 20, n);
        chk(32'(n >= CPM - 1 && n <= CPM + 3), 32'h1);
        wait_pin(2, 1'b0, 30, n);
        chk(32'(n >= 2 * CPM - 1 && n <= 2 * CPM + 3), 32'h1);
        key_b <= 1'b0;
        wait_pin(1, 1'b0, 600, n);
        rd(fjs_pkg::ADR_IRQ_STAT, 32'h1, 32'h1);
        // Manual keys over every swap, fast and key combination.
        for (int i = 0; i < 8; i++) begin
            wr(fjs_pkg::ADR_CFG, {29'h0, i[0], i[1], 1'b0});
            key_a <= !i[2];
            key_b <= i[2];
            wait_pin(1, 1'b1, 12, n);
            repeat (2) @(posedge mclk);
            #1;
            chk(32'(dir_fwd), 32'(!i[2] ^ i[0]));
            chk(32'(fast_jog), 32'(i[1]));
            key_a <= 1'b0;
            key_b <= 1'b0;
            wait_pin(1, 1'b0, 40, n);
        end
        // Homing, forward and backward codes, fast never used.
        for (int c = 1; c < 3; c++) begin
            wr(fjs_pkg::ADR_CFG, {27'h0, c[1:0], 3'h3});
            fast_seen = 1'b0;
            wr(fjs_pkg::ADR_CMD, 32'h4);
            wait_pin(1, 1'b1, 12, n);
            chk(32'(dir_fwd), 32'(c == 2));
            if (c == 1) begin
                home_sw <= 1'b1;
                wait_pin(2, 1'b1, 60, n);
                home_sw <= 1'b0;
                wait_pin(1, 1'b0, 200, n);
                rd(fjs_pkg::ADR_IRQ_STAT, 32'h2, 32'h2);
            end else begin
                wr(fjs_pkg::ADR_CMD, 32'h2);
                wait_pin(1, 1'b0, 20, n);
            end
            chk(32'(fast_seen), 32'h0);
        end
        repeat (3) @(posedge mclk);
        wrap_up();
    end
endmodule

// ===== fjs_drive_model.sv
`timescale 1ns/1ps
// ==========================================================
// Drive power stage: fast jog moves four units a cycle, slow jog one.
// The bench offset lets a scenario knock the axis out of its band.
module fjs_drive_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Jog signals from the sequencer
    input wire logic fast_jog,
    input wire logic slow_jog,
    input wire logic dir_fwd,
    // Disturbance and position
    input wire logic signed [31:0] bump,
    output logic signed [31:0] act_pos
);
    logic signed [31:0] pos_q;
    logic signed [31:0] step;
    assign step = fast_jog ? 32'sd4 : (slow_jog ? 32'sd1 : 32'sd0);
    assign act_pos = pos_q + bump;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pos_q <= 32'sd0;
        end else begin
            pos_q <= dir_fwd ? pos_q + step : pos_q - step;
        end
    end
endmodule

// ===== fjs_pkg.sv
package fjs_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_CFG = 8'h04;
    localparam logic [7:0] ADR_TARGET = 8'h08;
    localparam logic [7:0] ADR_FWD_SLOW = 8'h0c;
    localparam logic [7:0] ADR_FWD_COAST = 8'h10;
    localparam logic [7:0] ADR_REV_SLOW = 8'h14;
    localparam logic [7:0] ADR_REV_COAST = 8'h18;
    localparam logic [7:0] ADR_REV_SLOW_TIME = 8'h1c;
    localparam logic [7:0] ADR_REV_COAST_TIME = 8'h20;
    localparam logic [7:0] ADR_START_DELAY = 8'h24;
    localparam logic [7:0] ADR_TOL_BELOW = 8'h28;
    localparam logic [7:0] ADR_TOL_ABOVE = 8'h2c;
    localparam logic [7:0] ADR_STATUS = 8'h30;
    localparam logic [7:0] ADR_IRQ_STAT = 8'h34;
    localparam logic [7:0] ADR_IRQ_MASK = 8'h38;
    localparam logic [7:0] ADR_POSITION = 8'h3c;
    // ==========================================================
    // Field positions
    localparam int CMD_START = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_HOME = 2;
    localparam int CFG_POS_FAST = 0;
    localparam int CFG_MAN_FAST = 1;
    localparam int CFG_SWAP_KEYS = 2;
    localparam int CFG_HOME_LO = 3;
    localparam int ST_FAST = 4;
    localparam int ST_SLOW = 5;
    localparam int ST_DIR = 6;
    localparam int ST_IN_POS = 7;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_HOMED = 1;
    localparam int IRQ_LEFT_BAND = 2;
    localparam int IRQ_W = 3;
    // ==========================================================
    // Homing direction codes
    localparam logic [1:0] HOME_NONE = 2'h0;
    localparam logic [1:0] HOME_FWD = 2'h1;
    localparam logic [1:0] HOME_BWD = 2'h2;
    // ==========================================================
    // Widths, limits and reset values
    localparam int DIST_W = 27;
    localparam int TIME_W = 14;
    localparam int PRE_W = 20;
    localparam logic [DIST_W-1:0] DIST_MAX = 27'h5f5e0ff;
    localparam logic [TIME_W-1:0] REV_TIME_MAX_MS = 14'h270f;
    localparam logic [TIME_W-1:0] START_DELAY_MAX_MS = 14'h2706;
    localparam logic [DIST_W-1:0] DIST_RST = 27'h0;
    localparam logic [TIME_W-1:0] TIME_RST = 14'h0;
    localparam logic [5:0] CFG_RST = 6'h0;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int TICK_MS = 1;
    localparam int CYCLES_PER_MS = CLK_MHZ * 1000 * TICK_MS;
    // ==========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_START, S_RUN, S_MAN, S_HOME1, S_HOME2, S_BRAKE, S_SETTLE
    } fjs_state_t;
endpackage

// ===== fjs_sequencer.sv
`timescale 1ns/1ps
module fjs_sequencer #(
    parameter int CYCLES_PER_MS = fjs_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Axis position, same clock domain
    input wire logic signed [31:0] act_pos,
    // Pins
    input wire logic key_a,
    input wire logic key_b,
    input wire logic home_sw,
    // Drive outputs
    output logic fast_jog,
    output logic slow_jog,
    output logic dir_fwd,
    output logic irq
);
    // ==========================================================
    // Helpers
    function automatic logic [fjs_pkg::DIST_W-1:0] clamp_dist(input logic [31:0] v);
        clamp_dist = (v > 32'(fjs_pkg::DIST_MAX)) ? fjs_pkg::DIST_MAX : v[fjs_pkg::DIST_W-1:0];
    endfunction

    function automatic logic [fjs_pkg::TIME_W-1:0] clamp_ms(input logic [31:0] v,
                                                           input logic [fjs_pkg::TIME_W-1:0] lim);
        clamp_ms = (v > 32'(lim)) ? lim : v[fjs_pkg::TIME_W-1:0];
    endfunction

    // ==========================================================
    // Registers
    fjs_pkg::fjs_state_t st_q, st_d, ret_q, ret_d;
    logic dir_q, dir_d, fast_q, fast_d, slow_q, slow_d;
    logic [5:0] cfg_q;
    logic signed [31:0] target_q;
    logic [fjs_pkg::DIST_W-1:0] fwd_slow_q, fwd_coast_q, rev_slow_q, rev_coast_q, tol_below_q, tol_above_q;
    logic [fjs_pkg::TIME_W-1:0] rev_slow_time_q, rev_coast_time_q, start_delay_q, tmr_q;
    logic [fjs_pkg::PRE_W-1:0] pre_q;
    logic [2:0] pin_s1_q, pin_s2_q;
    logic reached_q, in_pos_q, in_pos_d;
    logic [fjs_pkg::IRQ_W-1:0] ist_q, imask_q, ev_w;
    logic [31:0] rdata_q, rdata_d;
    logic tmr_load;
    logic [fjs_pkg::TIME_W-1:0] tmr_val;
    logic done_ev, home_ev;

    // ==========================================================
    // Decoding
    wire wr_cmd_w = reg_wr && (reg_addr == fjs_pkg::ADR_CMD);
    wire start_w = wr_cmd_w && reg_wdata[fjs_pkg::CMD_START];
    wire stop_w = wr_cmd_w && reg_wdata[fjs_pkg::CMD_STOP];
    wire home_go_w = wr_cmd_w && reg_wdata[fjs_pkg::CMD_HOME];
    wire pos_fast_w = cfg_q[fjs_pkg::CFG_POS_FAST];
    wire man_fast_w = cfg_q[fjs_pkg::CFG_MAN_FAST];
    wire swap_w = cfg_q[fjs_pkg::CFG_SWAP_KEYS];
    wire [1:0] home_dir_w = cfg_q[fjs_pkg::CFG_HOME_LO +: 2];
    wire home_bwd_w = (home_dir_w == fjs_pkg::HOME_BWD);
    wire key_a_w = pin_s2_q[0];
    wire key_b_w = pin_s2_q[1];
    wire home_sw_w = pin_s2_q[2];
    wire man_fwd_w = swap_w ? key_b_w : key_a_w;
    wire man_bwd_w = swap_w ? key_a_w : key_b_w;
    wire man_one_w = man_fwd_w ^ man_bwd_w;
    wire tick_w = (pre_q == fjs_pkg::PRE_W'(CYCLES_PER_MS - 1));
    wire tmr_zero_w = (tmr_q == '0);

    // Signed remaining distance in travel direction; overshoot shows as negative.
    wire signed [33:0] diff_w = {{2{target_q[31]}}, target_q} - {{2{act_pos[31]}}, act_pos};
    wire signed [33:0] rem_w = dir_q ? diff_w : -diff_w;
    wire [fjs_pkg::DIST_W-1:0] slow_dist_w = dir_q ? fwd_slow_q : rev_slow_q;
    wire [fjs_pkg::DIST_W-1:0] coast_dist_w = dir_q ? fwd_coast_q : rev_coast_q;
    wire at_slow_w = rem_w <= $signed({7'h0, slow_dist_w});
    wire at_coast_w = rem_w <= $signed({7'h0, coast_dist_w});
    wire start_dir_w = diff_w > 34'sh0;
    wire band_ok_w = (diff_w <= $signed({7'h0, tol_below_q})) && (-diff_w <= $signed({7'h0, tol_above_q}));

    // ==========================================================
    // Sequencer
    always_comb begin
        st_d = st_q;
        dir_d = dir_q;
        ret_d = ret_q;
        tmr_load = 1'b0;
        tmr_val = fjs_pkg::TIME_RST;
        done_ev = 1'b0;
        home_ev = 1'b0;
        case (st_q)
            fjs_pkg::S_IDLE: begin
                if (home_go_w && home_dir_w != fjs_pkg::HOME_NONE) begin
                    st_d = fjs_pkg::S_HOME1;
                    dir_d = home_bwd_w;
                end else if (start_w) begin
                    st_d = fjs_pkg::S_START;
                    dir_d = start_dir_w;
                    tmr_load = 1'b1;
                    tmr_val = start_delay_q;
                end else if (man_one_w) begin
                    st_d = fjs_pkg::S_MAN;
                    dir_d = man_fwd_w;
                end
            end
            fjs_pkg::S_START: begin
                if (tmr_zero_w) begin
                    st_d = fjs_pkg::S_RUN;
                end
            end
            fjs_pkg::S_RUN: begin
                if (start_w && start_dir_w != dir_q) begin
                    st_d = fjs_pkg::S_BRAKE;
                    ret_d = fjs_pkg::S_RUN;
                    tmr_load = 1'b1;
                    tmr_val = rev_slow_time_q;
                end else if (at_coast_w) begin
                    st_d = fjs_pkg::S_IDLE;
                    done_ev = 1'b1;
                end
            end
            fjs_pkg::S_MAN: begin
                if (!man_one_w) begin
                    st_d = fjs_pkg::S_IDLE;
                end else if (man_fwd_w != dir_q) begin
                    st_d = fjs_pkg::S_BRAKE;
                    ret_d = fjs_pkg::S_MAN;
                    tmr_load = 1'b1;
                    tmr_val = rev_slow_time_q;
                end
            end
            fjs_pkg::S_HOME1: begin
                if (home_sw_w) begin
                    st_d = fjs_pkg::S_BRAKE;
                    ret_d = fjs_pkg::S_HOME2;
                    tmr_load = 1'b1;
                    tmr_val = rev_slow_time_q;
                end
            end
            fjs_pkg::S_HOME2: begin
                if (!home_sw_w) begin
                    st_d = fjs_pkg::S_IDLE;
                    home_ev = 1'b1;
                end
            end
            fjs_pkg::S_BRAKE: begin
                if (tmr_zero_w) begin
                    st_d = fjs_pkg::S_SETTLE;
                    tmr_load = 1'b1;
                    tmr_val = rev_coast_time_q;
                end
            end
            fjs_pkg::S_SETTLE: begin
                if (tmr_zero_w) begin
                    st_d = ret_q;
                    dir_d = !dir_q;
                end
            end
            default: begin
                st_d = fjs_pkg::S_IDLE;
            end
        endcase
        if (stop_w) begin
            st_d = fjs_pkg::S_IDLE;
        end
    end

    // Outputs follow the state one cycle later, so a switch point costs one clock of travel.
    assign fast_d = ((st_q == fjs_pkg::S_RUN) && pos_fast_w && !at_slow_w && !at_coast_w && !stop_w)
                    || ((st_q == fjs_pkg::S_MAN) && man_fast_w && man_fwd_w == dir_q && !stop_w);
    assign slow_d = !stop_w && (((st_q == fjs_pkg::S_RUN) && !at_coast_w)
                    || (st_q == fjs_pkg::S_MAN && man_one_w) || st_q == fjs_pkg::S_HOME1
                    || st_q == fjs_pkg::S_HOME2 || st_q == fjs_pkg::S_BRAKE);
    assign in_pos_d = (reached_q || done_ev) && band_ok_w;
    assign ev_w = {in_pos_q && !in_pos_d && st_q == fjs_pkg::S_IDLE, home_ev, done_ev};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= fjs_pkg::S_IDLE;
            ret_q <= fjs_pkg::S_IDLE;
            dir_q <= 1'b0;
            fast_q <= 1'b0;
            slow_q <= 1'b0;
            reached_q <= 1'b0;
            in_pos_q <= 1'b0;
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            dir_q <= dir_d;
            fast_q <= fast_d;
            slow_q <= slow_d;
            in_pos_q <= in_pos_d;
            reached_q <= in_pos_d && (st_d == fjs_pkg::S_IDLE);
            pin_s1_q <= {home_sw, key_b, key_a};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // Millisecond timer
    always_ff @(posedge mclk) begin
        if (!rst_n || tmr_load || tick_w) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
        if (!rst_n) begin
            tmr_q <= fjs_pkg::TIME_RST;
        end else if (tmr_load) begin
            tmr_q <= tmr_val;
        end else if (tick_w && !tmr_zero_w) begin
            tmr_q <= tmr_q - 1'b1;
        end
    end

    // ==========================================================
    // Register file
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_q <= fjs_pkg::CFG_RST;
            target_q <= '0;
            fwd_slow_q <= fjs_pkg::DIST_RST;
            fwd_coast_q <= fjs_pkg::DIST_RST;
            rev_slow_q <= fjs_pkg::DIST_RST;
            rev_coast_q <= fjs_pkg::DIST_RST;
            tol_below_q <= fjs_pkg::DIST_RST;
            tol_above_q <= fjs_pkg::DIST_RST;
            rev_slow_time_q <= fjs_pkg::TIME_RST;
            rev_coast_time_q <= fjs_pkg::TIME_RST;
            start_delay_q <= fjs_pkg::TIME_RST;
            imask_q <= '0;
            ist_q <= '0;
            rdata_q <= '0;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    fjs_pkg::ADR_CFG: cfg_q <= reg_wdata[5:0];
                    fjs_pkg::ADR_TARGET: target_q <= reg_wdata;
                    fjs_pkg::ADR_FWD_SLOW: fwd_slow_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_FWD_COAST: fwd_coast_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_REV_SLOW: rev_slow_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_REV_COAST: rev_coast_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_TOL_BELOW: tol_below_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_TOL_ABOVE: tol_above_q <= clamp_dist(reg_wdata);
                    fjs_pkg::ADR_REV_SLOW_TIME: rev_slow_time_q <= clamp_ms(reg_wdata, fjs_pkg::REV_TIME_MAX_MS);
                    fjs_pkg::ADR_REV_COAST_TIME: rev_coast_time_q <= clamp_ms(reg_wdata, fjs_pkg::REV_TIME_MAX_MS);
                    fjs_pkg::ADR_START_DELAY: start_delay_q <= clamp_ms(reg_wdata, fjs_pkg::START_DELAY_MAX_MS);
                    fjs_pkg::ADR_IRQ_MASK: imask_q <= reg_wdata[fjs_pkg::IRQ_W-1:0];
                    default: begin
                    end
                endcase
            end
            // A new event wins over a write-one-to-clear in the same cycle.
            if (reg_wr && reg_addr == fjs_pkg::ADR_IRQ_STAT) begin
                ist_q <= (ist_q & ~reg_wdata[fjs_pkg::IRQ_W-1:0]) | ev_w;
            end else begin
                ist_q <= ist_q | ev_w;
            end
            rdata_q <= reg_rd ? rdata_d : 32'h0;
        end
    end

    always_comb begin
        case (reg_addr)
            fjs_pkg::ADR_CFG: rdata_d = {26'h0, cfg_q};
            fjs_pkg::ADR_TARGET: rdata_d = target_q;
            fjs_pkg::ADR_FWD_SLOW: rdata_d = {5'h0, fwd_slow_q};
            fjs_pkg::ADR_FWD_COAST: rdata_d = {5'h0, fwd_coast_q};
            fjs_pkg::ADR_REV_SLOW: rdata_d = {5'h0, rev_slow_q};
            fjs_pkg::ADR_REV_COAST: rdata_d = {5'h0, rev_coast_q};
            fjs_pkg::ADR_TOL_BELOW: rdata_d = {5'h0, tol_below_q};
            fjs_pkg::ADR_TOL_ABOVE: rdata_d = {5'h0, tol_above_q};
            fjs_pkg::ADR_REV_SLOW_TIME: rdata_d = {18'h0, rev_slow_time_q};
            fjs_pkg::ADR_REV_COAST_TIME: rdata_d = {18'h0, rev_coast_time_q};
            fjs_pkg::ADR_START_DELAY: rdata_d = {18'h0, start_delay_q};
            fjs_pkg::ADR_STATUS: rdata_d = {24'h0, in_pos_q, dir_q, slow_q, fast_q, st_q};
            fjs_pkg::ADR_IRQ_STAT: rdata_d = {29'h0, ist_q};
            fjs_pkg::ADR_IRQ_MASK: rdata_d = {29'h0, imask_q};
            fjs_pkg::ADR_POSITION: rdata_d = act_pos;
            default: rdata_d = 32'h0;
        endcase
    end

    assign reg_rdata = rdata_q;
    assign fast_jog = fast_q;
    assign slow_jog = slow_q;
    assign dir_fwd = dir_q;
    assign irq = |(ist_q & imask_q);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    home_no_fast_a: assert property ((st_q == fjs_pkg::S_HOME1 || st_q == fjs_pkg::S_HOME2) |=> !fast_q)
        else $error("Fast jog driven during homing.");
    pos_fast_opt_a: assert property ((st_q == fjs_pkg::S_RUN && !pos_fast_w) |=> !fast_q)
        else $error("Fast jog in positioning without option.");
    man_fast_opt_a: assert property ((st_q == fjs_pkg::S_MAN && !man_fast_w) |=> !fast_q)
        else $error("Fast jog in manual without option.");
    start_delay_a: assert property ((st_q == fjs_pkg::S_START) |=> !slow_q && !fast_q)
        else $error("Jog output during start delay.");
    coast_point_a: assert property ((st_q == fjs_pkg::S_RUN && at_coast_w) |=> !slow_q && !fast_q)
        else $error("Slow jog kept past coast point.");
    slow_point_a: assert property ((st_q == fjs_pkg::S_RUN && at_slow_w) |=> !fast_q ##0 (slow_q || at_coast_w
        || $past(at_coast_w)))
        else $error("Fast jog kept past slowdown point.");
    settle_off_a: assert property ((st_q == fjs_pkg::S_SETTLE) |=> !fast_q && !slow_q)
        else $error("Jog output during reversal coast.");
    brake_end_a: assert property ((st_q == fjs_pkg::S_BRAKE && tmr_zero_w && !stop_w)
        |=> st_q == fjs_pkg::S_SETTLE && tmr_q == rev_coast_time_q)
        else $error("Reversal slowdown did not hand over to coast.");
    band_hold_a: assert property (in_pos_q |-> $past(band_ok_w))
        else $error("In-position held outside tolerance band.");
    home_dir_a: assert property ((st_q == fjs_pkg::S_IDLE && home_go_w && home_dir_w != fjs_pkg::HOME_NONE
        && !stop_w) |=> st_q == fjs_pkg::S_HOME1 && dir_q == $past(home_bwd_w))
        else $error("Homing started in wrong direction.");

    run_done_c: cover property (st_q == fjs_pkg::S_RUN ##1 st_q == fjs_pkg::S_IDLE && in_pos_q);
    reversal_c: cover property (st_q == fjs_pkg::S_BRAKE ##[1:50] st_q == fjs_pkg::S_SETTLE);
    homing_c: cover property (st_q == fjs_pkg::S_HOME2 ##1 st_q == fjs_pkg::S_IDLE);
endmodule
